// [rtl/fsg_top.sv]
// Flash signature engine with ECC status and Wishbone register access.
// Assumes a flash array with a one-request read port and a fetch port.
`timescale 1ns/1ns
`default_nettype none
module fsg_top
  import fsg_pkg::*;
#(
  parameter logic [CRC_W-1:0] SEED      = CRC_SEED,
  parameter bit               MSB_FIRST = 1'b0
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output fsg_pkg::fsg_frd_req_type    frd_req_o,
  input  wire fsg_pkg::fsg_frd_rsp_type frd_rsp_i,
  input  wire logic [71:0]            frd_raw_i,
  input  wire logic                   fetch_req_i,
  input  wire logic                   fetch_blk_i,
  output logic                        fetch_stall_o,
  output logic                        fetch_err_o,
  output logic                        busy_o
);
  import fsg_pkg::*;

  typedef struct packed {
    fsg_state_type      st;
    logic [ADDR_W-1:0]  start_addr;
    logic [ADDR_W-1:0]  end_addr;
    logic [LOC_W-1:0]   loc;
    logic [LOC_W-1:0]   last_loc;
    logic [CRC_W-1:0]   crc;
    logic [CRC_W-1:0]   sign;
    logic [63:0]        word;
    logic               run_corr;
    logic               run_unc;
    logic               blk;
    logic               por_run;
    logic               done;
    logic               fail;
    logic               corr;
    logic               unc;
    logic               por_fail;
    logic               ecc_en;
    logic               key_ok;
    logic               ack;
    logic [31:0]        rdata;
  } fsg_regs_type;

  fsg_regs_type r_reg;
  fsg_regs_type r_next;

  logic [63:0]      ecc_data;
  logic             ecc_corr;
  logic             ecc_unc;
  logic [CRC_W-1:0] crc_step;
  logic [31:0]      crc_word;
  logic             wb_req;
  logic             wr_en;

  fsg_ecc u_ecc (
    .data_i (frd_raw_i[63:0]),
    .ecc_i  (frd_raw_i[71:64]),
    .en_i   (r_reg.ecc_en),
    .data_o (ecc_data),
    .corr_o (ecc_corr),
    .unc_o  (ecc_unc)
  );

  assign crc_word = (r_reg.st == FSG_HI) ? r_reg.word[63:32] : r_reg.word[31:0];

  fsg_crc24 #(.MSB_FIRST(MSB_FIRST)) u_crc (
    .crc_i  (r_reg.crc),
    .word_i (crc_word),
    .crc_o  (crc_step)
  );

  function automatic logic [LOC_W-1:0] loc_of(input logic [ADDR_W-1:0] a, input logic top);
    // Page selector only; top picks the last 64-bit location of the page
    loc_of = {a[ADDR_W-1:PAGE_LSB], {(PAGE_LSB-3){top}}};
  endfunction

  assign wb_req = wb_cyc_i && wb_stb_i && !r_reg.ack;
  assign wr_en  = wb_req && wb_we_i && (wb_sel_i == 4'hf);

  always_comb begin
    r_next = r_reg;
    r_next.ack = wb_req;
    r_next.rdata = 32'h0000_0000;
    r_next.done = r_reg.done;

    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_START: begin
          r_next.rdata = 32'(r_reg.start_addr);
        end
        OFS_END: begin
          r_next.rdata = 32'(r_reg.end_addr);
        end
        OFS_STATUS: begin
          r_next.rdata[ST_BUSY]     = (r_reg.st != FSG_IDLE);
          r_next.rdata[ST_DONE]     = r_reg.done;
          r_next.rdata[ST_FAIL]     = r_reg.fail;
          r_next.rdata[ST_CORR]     = r_reg.corr;
          r_next.rdata[ST_UNC]      = r_reg.unc;
          r_next.rdata[ST_POR_FAIL] = r_reg.por_fail;
          // Reading status clears the sticky run results
          r_next.done = 1'b0;
          r_next.corr = 1'b0;
          r_next.unc  = 1'b0;
          r_next.fail = 1'b0;
        end
        OFS_SIGN: begin
          r_next.rdata = 32'(r_reg.sign);
        end
        OFS_ECCDIS: begin
          r_next.rdata = {31'h0000_0000, r_reg.ecc_en};
        end
        default: begin
          r_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (wr_en) begin
      case (wb_adr_i)
        OFS_START: begin
          // Range ignored while a run is active to keep it coherent
          if (r_reg.st == FSG_IDLE) begin
            r_next.start_addr = wb_dat_i[ADDR_W-1:0];
          end
        end
        OFS_END: begin
          if (r_reg.st == FSG_IDLE) begin
            r_next.end_addr = wb_dat_i[ADDR_W-1:0];
          end
        end
        OFS_KEY: begin
          r_next.key_ok = (wb_dat_i == ECC_KEY);
        end
        OFS_ECCDIS: begin
          if (r_reg.key_ok) begin
            r_next.ecc_en = wb_dat_i[0];
            r_next.key_ok = 1'b0;
          end
        end
        OFS_CMD: begin
          if (wb_dat_i == CMD_SIGN && r_reg.st == FSG_IDLE) begin
            r_next.st       = FSG_REQ;
            r_next.loc      = loc_of(r_reg.start_addr, 1'b0);
            r_next.last_loc = loc_of(r_reg.end_addr, 1'b1);
            r_next.blk      = r_reg.start_addr[ADDR_W-1];
            r_next.crc      = SEED;
            r_next.run_corr = 1'b0;
            r_next.run_unc  = 1'b0;
            r_next.por_run  = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    case (r_reg.st)
      FSG_IDLE: begin
      end
      FSG_REQ: begin
        r_next.st = FSG_WAIT;
      end
      FSG_WAIT: begin
        if (frd_rsp_i.valid) begin
          r_next.word     = ecc_data;
          r_next.run_corr = r_reg.run_corr | ecc_corr;
          r_next.run_unc  = r_reg.run_unc | ecc_unc;
          r_next.st       = FSG_LO;
        end
      end
      FSG_LO: begin
        r_next.crc = crc_step;
        r_next.st  = FSG_HI;
      end
      FSG_HI: begin
        if (r_reg.loc == r_reg.last_loc) begin
          r_next.st = FSG_CHECK;
        end else begin
          r_next.crc = crc_step;
          r_next.loc = r_reg.loc + 1'b1;
          r_next.st  = FSG_REQ;
        end
      end
      FSG_CHECK: begin
        r_next.sign = r_reg.crc;
        r_next.done = 1'b1;
        r_next.fail = (r_reg.word[63:64-CRC_W] != r_reg.crc) | r_reg.fail;
        r_next.corr = r_reg.corr | r_reg.run_corr;
        r_next.unc  = r_reg.unc | r_reg.run_unc;
        if (r_reg.por_run) begin
          // Corrected errors alone do not fail the kernel check
          r_next.por_fail = r_reg.run_unc | (r_reg.word[63:64-CRC_W] != r_reg.crc);
        end
        r_next.por_run = 1'b0;
        r_next.st = FSG_IDLE;
      end
      default: begin
        r_next.st = FSG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg          <= '0;
      r_reg.st       <= FSG_REQ;
      r_reg.por_run  <= 1'b1;
      r_reg.loc      <= {KERNEL_START_PG, {(PAGE_LSB-3){1'b0}}};
      r_reg.last_loc <= {KERNEL_END_PG, {(PAGE_LSB-3){1'b1}}};
      r_reg.crc      <= SEED;
      r_reg.ecc_en   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign frd_req_o.req = (r_reg.st == FSG_REQ);
  assign frd_req_o.loc = r_reg.loc;
  assign busy_o        = (r_reg.st != FSG_IDLE);
  assign fetch_stall_o = fetch_req_i && busy_o && (fetch_blk_i == r_reg.blk);
  assign fetch_err_o   = fetch_req_i && r_reg.por_fail && !fetch_stall_o;
  assign wb_ack_o      = r_reg.ack;
  assign wb_dat_o      = r_reg.rdata;

  sequence seq_lo_hi;
    r_reg.st == FSG_LO ##1 r_reg.st == FSG_HI;
  endsequence

  halves_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (r_reg.st == FSG_WAIT && frd_rsp_i.valid) |=> seq_lo_hi)
    else $error("low half not followed by high half");
  ecc_reset_on_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> r_reg.ecc_en)
    else $error("ecc not enabled after reset");
  por_start_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (r_reg.st == FSG_REQ && r_reg.por_run))
    else $error("kernel check not started");
  sign_publish_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (r_reg.st == FSG_CHECK) |=> (r_reg.sign == $past(r_reg.crc) && r_reg.done))
    else $error("signature not published");
  fail_report_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (r_reg.st == FSG_CHECK && r_reg.word[63:40] != r_reg.crc) |=> r_reg.fail)
    else $error("mismatch not reported");
  corr_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (r_reg.st == FSG_CHECK && r_reg.run_corr) |=> r_reg.corr)
    else $error("corrected flag missing");
  unc_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (r_reg.st == FSG_CHECK && r_reg.run_unc) |=> r_reg.unc)
    else $error("uncorrectable flag missing");
  fetch_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_req_i && busy_o && fetch_blk_i == r_reg.blk) |-> fetch_stall_o && !fetch_err_o)
    else $error("fetch not stalled");
  por_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (r_reg.por_fail && fetch_req_i && !busy_o) |-> fetch_err_o)
    else $error("fetch not refused after kernel failure");
  page_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (frd_req_o.req && $past(r_reg.st) == FSG_IDLE) |-> r_reg.loc[6:0] == 7'h00)
    else $error("start not page aligned");
endmodule
`default_nettype wire

// [rtl/fsg_pkg.sv]
// Package for the flash signature engine: register map, fields, timing.
// Assumes a single 20 MHz clock domain and a classic Wishbone slave.
package fsg_pkg;

  localparam int unsigned ADDR_W   = 20;
  localparam int unsigned PAGE_LSB = 10;
  localparam int unsigned PAGE_W   = ADDR_W - PAGE_LSB;
  localparam int unsigned LOC_W    = ADDR_W - 3;
  localparam int unsigned CRC_W    = 24;

  // Register byte offsets
  localparam logic [7:0] OFS_START  = 8'h00;
  localparam logic [7:0] OFS_END    = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_SIGN   = 8'h10;
  localparam logic [7:0] OFS_ECCDIS = 8'h14;
  localparam logic [7:0] OFS_KEY    = 8'h18;

  localparam logic [31:0] CMD_SIGN   = 32'h0000_0001;
  localparam logic [31:0] ECC_KEY    = 32'h5a5a_0ecc;

  // Status bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_FAIL = 2;
  localparam int unsigned ST_CORR = 3;
  localparam int unsigned ST_UNC  = 4;
  localparam int unsigned ST_POR_FAIL = 5;

  // Kernel region in the first block
  localparam logic [PAGE_W-1:0] KERNEL_START_PG = 10'h000;
  localparam logic [PAGE_W-1:0] KERNEL_END_PG   = 10'h007;

  localparam logic [CRC_W-1:0] CRC_POLY = 24'h80_0063;
  localparam logic [CRC_W-1:0] CRC_SEED = 24'hff_ffff;

  // Nominal full-block run, guideline only
  localparam real         SIGN_TIME_MS   = 8.192;
  localparam real         CLK_MHZ        = 20.0;
  localparam int unsigned SIGN_NOM_CYC   = int'(SIGN_TIME_MS * CLK_MHZ * 1000.0 - 0.5);

  typedef enum logic [2:0] {
    FSG_IDLE  = 3'b000,
    FSG_REQ   = 3'b001,
    FSG_WAIT  = 3'b010,
    FSG_LO    = 3'b011,
    FSG_HI    = 3'b100,
    FSG_CHECK = 3'b101
  } fsg_state_type;

  typedef struct packed {
    logic            req;
    logic [LOC_W-1:0] loc;
  } fsg_frd_req_type;

  typedef struct packed {
    logic        valid;
    logic [63:0] data;
    logic        corr;
    logic        unc;
  } fsg_frd_rsp_type;

endpackage

// [rtl/fsg_crc24.sv]
// 24-bit CRC step over one 32-bit word, combinational.
// Assumes the caller holds the remainder register.
`timescale 1ns/1ns
`default_nettype none
module fsg_crc24
  import fsg_pkg::*;
#(
  parameter bit MSB_FIRST = 1'b0
) (
  input  wire logic [CRC_W-1:0] crc_i,
  input  wire logic [31:0]      word_i,
  output logic      [CRC_W-1:0] crc_o
);
  always_comb begin
    logic [CRC_W-1:0] c;
    logic             fb;
    c = crc_i;
    fb = 1'b0;
    for (int i = 0; i < 32; i++) begin
      fb = c[CRC_W-1] ^ (MSB_FIRST ? word_i[31-i] : word_i[i]);
      c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    end
    crc_o = c;
  end
endmodule
`default_nettype wire

// [rtl/fsg_ecc.sv]
// Hamming SEC-DED check of a 72-bit flash word (64 data + 8 check).
// Assumes check bits are even parity per syndrome bit plus overall.
`timescale 1ns/1ns
`default_nettype none
module fsg_ecc
  import fsg_pkg::*;
(
  input  wire logic [63:0] data_i,
  input  wire logic [7:0]  ecc_i,
  input  wire logic        en_i,
  output logic      [63:0] data_o,
  output logic             corr_o,
  output logic             unc_o
);
  // Data bit k sits at the k-th codeword position that is not a power of two,
  // so a single check-bit error can never be mistaken for a data-bit error
  function automatic logic [6:0] code_of(input int unsigned k);
    logic [6:0]  res;
    int unsigned n;
    res = 7'h00;
    n   = 0;
    for (int unsigned p = 3; p < 128; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == k) begin
          res = 7'(p);
        end
        n++;
      end
    end
    code_of = res;
  endfunction

  always_comb begin
    logic [6:0] syn;
    logic       par;
    syn = ecc_i[6:0];
    par = ^{data_i, ecc_i};
    data_o = data_i;
    for (int k = 0; k < 64; k++) begin
      if (data_i[k]) begin
        syn = syn ^ code_of(k);
      end
    end
    corr_o = 1'b0;
    unc_o  = 1'b0;
    if (en_i && (syn != 7'h00 || par)) begin
      if (par) begin
        corr_o = 1'b1;
        for (int k = 0; k < 64; k++) begin
          if (code_of(k) == syn) begin
            data_o[k] = ~data_i[k];
          end
        end
      end else begin
        unc_o = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/fsg_flash_model.sv]
// Flash array read port model for the signature engine bench.
// Assumes the one-request read port: a req pulse, then one valid cycle.
`timescale 1ns/1ns
`default_nettype none
module fsg_flash_model
  import fsg_pkg::*;
(
  input  wire fsg_pkg::fsg_frd_req_type frd_req_i,
  input  wire logic                     clk_i,
  output fsg_pkg::fsg_frd_rsp_type      frd_rsp_o,
  output logic [71:0]                   frd_raw_o
);
  import fsg_pkg::*;
  logic [71:0] mem [int];
  logic [71:0] hold_reg;
  int          wait_reg;

  initial begin
    frd_rsp_o = '0;
    frd_raw_o = '0;
    wait_reg  = -1;
  end

  // Latency follows the low location bits, so runs mix prompt and slow answers
  always @(posedge clk_i) begin
    frd_rsp_o <= '0;
    // Data outside the valid cycle toggles every cycle, so every other cycle repeats the last word
    frd_raw_o <= ~frd_raw_o;
    if (frd_req_i.req) begin
      hold_reg <= mem.exists(int'(frd_req_i.loc)) ? mem[int'(frd_req_i.loc)] : 72'h0;
      wait_reg <= int'(frd_req_i.loc[1:0]);
    end else if (wait_reg == 0) begin
      frd_rsp_o <= '{valid: 1'b1, data: hold_reg[63:0], corr: 1'b0, unc: 1'b0};
      frd_raw_o <= hold_reg;
      wait_reg  <= -1;
    end else if (wait_reg > 0) begin
      wait_reg <= wait_reg - 1;
    end
  end
endmodule
`default_nettype wire

// [dv/tb_fsg_top.sv]
// Self-checking bench for the flash signature engine.
// Assumes the flash model beside it; zero seed so erased-zero flash signs to 0.
`timescale 1ns/1ns
`default_nettype none
module tb_fsg_top;
  import fsg_pkg::*;
  localparam logic [23:0] SEED_V = 24'h000000;
  logic                   clk   = 1'b0;
  logic                   rst   = 1'b1;
  logic                   cyc   = 1'b0;
  logic                   stb   = 1'b0;
  logic                   we    = 1'b0;
  logic [7:0]             adr   = 8'h00;
  logic [31:0]            wdat  = 32'h0;
  logic                   freq  = 1'b1;
  logic                   fblk  = 1'b0;
  logic [31:0]            rdat;
  logic                   ack;
  logic                   stall;
  logic                   ferr;
  logic                   busy;
  logic [71:0]            raw;
  fsg_frd_req_type        req;
  fsg_frd_rsp_type        rsp;
  integer                 seed  = 37516;
  int                     errors   = 0;
  int                     compares = 0;
  logic [63:0]            exq[$];
  logic [63:0]            note;

  always #25 clk = ~clk;

  fsg_top #(.SEED(SEED_V), .MSB_FIRST(1'b0)) fsg_top_inst (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .frd_req_o(req), .frd_rsp_i(rsp), .frd_raw_i(raw),
    .fetch_req_i(freq), .fetch_blk_i(fblk), .fetch_stall_o(stall),
    .fetch_err_o(ferr), .busy_o(busy));

  fsg_flash_model fsg_flash_model_inst (
    .frd_req_i(req), .clk_i(clk), .frd_rsp_o(rsp), .frd_raw_o(raw));

  task automatic end_sim();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("BAD %s exp %h seen %h", name, want, seen);
    end
  endtask

  // Expected read value and mask are queued; the monitor compares on ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    if (!w) exq.push_back({m, e});
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      note = exq.pop_front();
      chk("wb_dat_o", rdat & note[63:32], note[31:0]);
    end
  end

  function automatic logic [23:0] crc_w(input logic [23:0] c, input logic [31:0] w);
    logic fb;
    for (int i = 0; i < 32; i++) begin
      fb = c[23] ^ w[i];
      c  = {c[22:0], 1'b0} ^ (fb ? CRC_POLY : 24'h0);
    end
    return c;
  endfunction

  task automatic wait_idle();
    @(negedge clk);
    while (busy !== 1'b0) @(negedge clk);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst  <= 1'b1;
    fblk <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("busy_o", busy, 1);
    chk("fetch_stall_o", stall, 1);
  endtask

  // One sign run over np pages from page sp; flip corrupts the fourth location
  task automatic run(input int sp, input int np, input logic [71:0] flip,
                     input logic rnd, input logic bad);
    logic [23:0] c;
    logic [63:0] d;
    logic [31:0] r;
    int          base;
    int          last;
    int          ep;
    int          nb;
    base = sp * 128;
    last = (sp + np) * 128 - 1;
    ep   = sp + np - 1;
    nb   = $countones(flip);
    c    = SEED_V;
    for (int l = base; l <= last; l++) begin
      r = $random(seed);
      d = rnd ? {r, $random(seed)} : 64'h0;
      c = crc_w(c, d[31:0]);
      if (l == last) d[63:40] = c ^ {23'h0, bad};
      else c = crc_w(c, d[63:32]);
      fsg_flash_model_inst.mem[l] = {rnd ? r[7:0] : 8'h00, d} ^ ((l == base + 3) ? flip : 72'h0);
    end
    r = $random(seed);
    wb(1'b1, OFS_START, {12'h0, sp[9:0], r[9:0]}, 0, 0);
    wb(1'b1, OFS_END, {12'h0, ep[9:0], r[19:10]}, 0, 0);
    wb(1'b1, OFS_CMD, CMD_SIGN, 0, 0);
    fblk <= sp[9];
    @(negedge clk);
    chk("fetch_stall_o", stall, 1);
    @(posedge clk);
    fblk <= ~sp[9];
    @(negedge clk);
    chk("fetch_stall_o", stall, 0);
    wait_idle();
    wb(1'b0, OFS_STATUS, 0, {27'h0, 2'b11, nb != 2, 2'b11},
       {27'h0, nb == 2, nb == 1, bad, 2'b10});
    wb(1'b0, OFS_SIGN, 0, (nb == 2) ? 32'h0 : 32'h00ff_ffff, {8'h0, c});
  endtask

  initial begin
    fsg_flash_model_inst.mem[9] = 72'h1;
    do_reset();
    wait_idle();
    chk("fetch_err_o", ferr, 0);
    wb(1'b0, OFS_STATUS, 0, 32'h20, 32'h0);
    wb(1'b0, OFS_ECCDIS, 0, 32'h1, 32'h1);
    wb(1'b1, OFS_ECCDIS, 0, 0, 0);
    wb(1'b0, OFS_ECCDIS, 0, 32'h1, 32'h1);
    wb(1'b1, OFS_KEY, ECC_KEY, 0, 0);
    wb(1'b1, OFS_ECCDIS, 0, 0, 0);
    wb(1'b0, OFS_ECCDIS, 0, 32'h1, 32'h0);
    wb(1'b0, 8'hfc, 0, 32'hffff_ffff, 32'h0);
    run(16 + ($random(seed) & 255), 2, 72'h0, 1'b1, 1'b0);
    run(520 + ($random(seed) & 255), 3, 72'h0, 1'b1, 1'b1);
    // Checked decoding needs ECC back on, and zero words are valid codewords
    wb(1'b1, OFS_KEY, ECC_KEY, 0, 0);
    wb(1'b1, OFS_ECCDIS, 32'h1, 0, 0);
    run(800, 1, 72'h10, 1'b0, 1'b0);
    run(900, 1, 72'h11, 1'b0, 1'b0);
    fsg_flash_model_inst.mem[5] = 72'h3;
    do_reset();
    wait_idle();
    chk("fetch_err_o", ferr, 1);
    wb(1'b0, OFS_STATUS, 0, 32'h20, 32'h20);
    end_sim();
  end

  // Expected run is about 19k cycles
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
